// file: core/mct_defines.svh
// Constants for the motor-control PWM timer
`ifndef MCT_DEFINES_SVH
`define MCT_DEFINES_SVH
`define MCT_NUM_CH     4        // Capture/compare channels
`define MCT_NUM_PAIRS  3        // Complementary pairs (three phases)
`define MCT_CNT_W      16       // Standard counter width
`define MCT_PSC_W      16       // Prescaler width
`define MCT_DT_W       8        // Dead-time count width
`define MCT_HALL_N     3        // Hall sensor inputs
`define MCT_ADC_UPD    3'h4     // ADC source code for update event
`endif

// file: core/mct_pkg.sv
// Types shared by the motor-control PWM timer files
package mct_pkg;
    // Counter direction policy
    typedef enum logic [1:0] {
        CNT_UP     = 2'b00,
        CNT_DOWN   = 2'b01,
        CNT_CENTER = 2'b10
    } count_mode_t;
    // Reaction to the inter-timer trigger
    typedef enum logic [1:0] {
        SLV_FREE    = 2'b00,
        SLV_RESET   = 2'b01,
        SLV_GATED   = 2'b10,
        SLV_ENCODER = 2'b11
    } slave_mode_t;
    // Per-channel function
    typedef enum logic [1:0] {
        CH_CAPTURE = 2'b00,
        CH_COMPARE = 2'b01,
        CH_PWM     = 2'b10,
        CH_ONESHOT = 2'b11
    } ch_mode_t;
    // Channel configuration carrier
    typedef struct packed {
        ch_mode_t mode;     // Channel function
        logic     pol_low;  // Invert the reference output
    } ch_cfg_t;
    // Timer control carrier
    typedef struct packed {
        logic        enable;     // Counter runs
        count_mode_t cmode;      // Count direction policy
        slave_mode_t smode;      // Trigger reaction
        logic        one_pulse;  // Stop after one update
        logic        freeze_en;  // Freeze while debug halt
        logic        dma_en;     // DMA request on update
        logic        hall_en;    // Hall change captures channel 0
    } ctrl_t;
endpackage : mct_pkg

// file: core/mct_channel.sv
// One capture/compare channel of the timer
`timescale 1ns/1ps
module mct_channel import mct_pkg::*; #(
    parameter int W = 16                  // Counter width
) (
    input  wire logic         clock_i,    // Timer clock
    input  wire logic         nrst_i,     // Async reset, low
    input  wire ch_cfg_t      cfg_i,      // Channel configuration
    input  wire logic [W-1:0] cmp_i,      // Compare value
    input  wire logic [W-1:0] cnt_i,      // Counter value
    input  wire logic         tick_i,     // Counter advanced
    input  wire logic         run_i,      // Counter running
    input  wire logic         cap_evt_i,  // Capture event
    input  wire logic         clr_i,      // Clear capture flag
    output logic              ref_o,      // Reference output
    output logic [W-1:0]      cap_o,      // Captured value
    output logic              flag_o,     // Capture flag
    output logic              match_o     // Compare match pulse
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire logic below = cnt_i < cmp_i;          // Active window
    wire logic hit   = tick_i && cnt_i == cmp_i; // Compare hit
    wire logic cap   = cap_evt_i && cfg_i.mode == CH_CAPTURE;
    logic      tog;                            // Toggle state
    logic      next_ref;                       // Unpolarised ref
    always_comb begin
        unique case (cfg_i.mode)
            CH_CAPTURE: next_ref = 1'b0;
            CH_COMPARE: next_ref = tog;
            CH_PWM:     next_ref = below;                // [R5] [R8]
            CH_ONESHOT: next_ref = run_i && !below;
        endcase
    end
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Output, toggle and match
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tog     <= 1'b0;
            ref_o   <= 1'b0;
            match_o <= 1'b0;
        end else begin
            tog     <= tog ^ (hit && cfg_i.mode == CH_COMPARE);
            ref_o   <= next_ref ^ cfg_i.pol_low;          // [R4]
            match_o <= hit && cfg_i.mode != CH_CAPTURE;
        end
    end
    // Capture value and flag, set beats clear
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cap_o  <= '0;
            flag_o <= 1'b0;
        end else begin
            if (cap) cap_o <= cnt_i;                      // [R4]
            flag_o <= cap || (flag_o && !clr_i);
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    pwm_zero_duty_a: assert property ( // [R8]
        cfg_i.mode == CH_PWM && cmp_i == '0 && $stable(cfg_i)
        |=> ref_o == cfg_i.pol_low)
        else $error("zero duty pwm not inactive");
    capture_value_a: assert property ( // [R4]
        cap |=> cap_o == $past(cnt_i) && flag_o)
        else $error("capture lost counter value");
endmodule : mct_channel

// file: core/mct_dead_time.sv
// Complementary output pair with dead-time insertion
`timescale 1ns/1ps
module mct_dead_time #(
    parameter int DW = 8                  // Dead-time count width
) (
    input  wire logic          clock_i,   // Timer clock
    input  wire logic          nrst_i,    // Async reset, low
    input  wire logic          ref_i,     // Reference level
    input  wire logic [DW-1:0] dt_i,      // Dead time in cycles
    input  wire logic          off_i,     // Force both inactive
    output logic               p_o,       // Main output
    output logic               n_o        // Complementary output
);
    logic          cur;                   // Settled reference
    logic [DW-1:0] wait_cnt;              // Remaining dead time
    wire logic     chg  = ref_i != cur;   // Reference edge
    wire logic     idle = !chg && wait_cnt == '0 && !off_i;
    // Both sides drop on an edge, new side waits out the dead time
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur      <= 1'b0;
            wait_cnt <= '0;
            p_o      <= 1'b0;
            n_o      <= 1'b0;
        end else begin
            cur      <= ref_i;
            wait_cnt <= chg ? dt_i : wait_cnt - DW'(wait_cnt != '0); // [R6]
            p_o      <= idle && cur;                           // [R16]
            n_o      <= idle && !cur;                          // [R16]
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    pair_exclusive_a: assert property ( // [R16]
        !(p_o && n_o))
        else $error("both pair outputs active");
    dead_gap_a: assert property ( // [R6]
        $fell(n_o) && !off_i && dt_i != '0 |=> !p_o)
        else $error("no dead time before main output");
    forced_off_a: assert property ( // [R9]
        off_i |=> !p_o && !n_o)
        else $error("pair not off while forced");
endmodule : mct_dead_time

// file: core/motor_control_pwm_timer.sv
// Motor-control PWM timer: counter, channels, pairs, links
//
// Summary of operation
// R1 - Auto-reload 16-bit up, down, center counter
// R2 - Wide variant uses a 32-bit counter
// R3 - Prescaler divides by one to 65536
// R4 - Four channels: capture, compare, PWM, one-pulse
// R5 - Edge or center aligned PWM
// R6 - Complementary pairs with programmable dead time
// R7 - Three phases on six output lines
// R8 - Duty cycle from zero to full
// R9 - Debug halt freezes counter, forces outputs off; a trigger edge in reset mode still clears the counter
// R10 - Trigger exchange with other timers
// R11 - Own DMA request per timer
// R12 - Quadrature encoder counts up or down
// R13 - One to three hall sensor inputs
// R14 - Event output starts ADC conversion
// R15 - Reload at limit raises update flag
// R16 - Pair outputs never active together
`timescale 1ns/1ps
`include "mct_defines.svh"
module motor_control_pwm_timer import mct_pkg::*; #(
    parameter int W  = `MCT_CNT_W,        // Counter width, 16 or 32
    parameter int PW = `MCT_PSC_W,        // Prescaler width
    parameter int DW = `MCT_DT_W          // Dead-time width
) (
    input  wire logic          clock_i,       // Timer clock
    input  wire logic          nrst_i,        // Async reset, low
    input  wire ctrl_t         ctrl_i,        // Control bits
    input  wire logic [W-1:0]  reload_i,      // Auto-reload limit
    input  wire logic [PW-1:0] prescale_i,    // Divide factor minus one
    input  wire ch_cfg_t [3:0] ch_cfg_i,      // Channel configuration
    input  wire logic [W-1:0]  cmp_i [4],     // Compare values
    input  wire logic [DW-1:0] dead_i,        // Dead time in cycles
    input  wire logic [2:0]    adc_src_i,     // ADC trigger source
    input  wire logic          debug_halt_i,  // Processor halted
    input  wire logic          trig_i,        // Trigger from a timer
    input  wire logic [3:0]    pin_i,         // Channel input pins
    input  wire logic          update_clr_i,  // Clear update flag
    input  wire logic [3:0]    cap_clr_i,     // Clear capture flags
    output logic [W-1:0]       cnt_o,         // Counter value
    output logic               down_o,        // Counting down
    output logic               update_flag_o, // Sticky update flag
    output logic [3:0]         cap_flag_o,    // Sticky capture flags
    output logic [W-1:0]       cap_o [4],     // Captured values
    output logic [2:0]         pwm_p_o,       // Phase main outputs
    output logic [2:0]         pwm_n_o,       // Phase complement
    output logic               ch3_o,         // Channel 3 output
    output logic               dma_req_o,     // DMA request pulse
    output logic               adc_trig_o,    // ADC start pulse
    output logic               trig_o         // Trigger to timers
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] s1, s2, s3;                // Three-stage sync
    logic [3:0] pin;                       // Accepted pin level
    logic [3:0] pin_d;                     // Previous accepted level
    // Level accepted once stages two and three agree
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            pin   <= '0;
            pin_d <= '0;
        end else begin
            s1    <= pin_i;
            s2    <= s1;
            s3    <= s2;
            pin   <= (s2 & s3) | (pin & (s2 ^ s3));
            pin_d <= pin;
        end
    end
    wire logic [3:0] pin_rise = pin & ~pin_d;   // Capture edges
    // Hall change: any of the three sensors moved
    wire logic hall_chg = ctrl_i.hall_en &&
                          (pin[2:0] != pin_d[2:0]);            // [R13]
    // Quadrature: A on pin 0, B on pin 1
    wire logic enc_step = (pin[0] ^ pin_d[0]) | (pin[1] ^ pin_d[1]);
    wire logic enc_up   = pin[0] ^ pin_d[1];                    // [R12]
    // ----------------------------------------
    // Trigger and run control
    // ----------------------------------------
    logic       trig_d;                    // Previous trigger
    logic       opm_done;                  // One pulse finished
    logic [PW-1:0] psc_cnt;                // Prescaler count
    logic       upd;                       // Update this cycle
    wire logic  trig_rise = trig_i && !trig_d;                  // [R10]
    wire logic  frozen    = debug_halt_i && ctrl_i.freeze_en;   // [R9]
    wire logic  run       = ctrl_i.enable && !opm_done;
    wire logic  encoder   = ctrl_i.smode == SLV_ENCODER;
    wire logic  gate_ok   = ctrl_i.smode != SLV_GATED || trig_i;
    wire logic  srst      = run && ctrl_i.smode == SLV_RESET && trig_rise;
    // At or past the factor, so lowering it cannot stall the count
    wire logic  psc_hit   = psc_cnt >= prescale_i;              // [R3]
    wire logic  tick      = run && !frozen && !srst &&
                            (encoder ? enc_step : gate_ok && psc_hit);
    // Prescaler restarts at every tick
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            psc_cnt <= '0;
        end else if (srst || !run || tick || psc_hit) begin
            psc_cnt <= '0;                                      // [R3]
        end else if (!frozen && gate_ok && !encoder) begin
            psc_cnt <= psc_cnt + PW'(1);
        end
    end
    // Trigger history and one-pulse stop; trigger re-arms
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trig_d   <= 1'b0;
            opm_done <= 1'b0;
        end else begin
            trig_d <= trig_i;
            if (!ctrl_i.enable || trig_rise) opm_done <= 1'b0;  // [R10]
            else if (upd && ctrl_i.one_pulse) opm_done <= 1'b1; // [R4]
        end
    end
    // ----------------------------------------
    // Counter next value
    // ----------------------------------------
    // Limits of the count range
    wire logic at_top = cnt_o >= reload_i;
    wire logic at_bot = cnt_o == '0;
    wire logic go_up  = encoder ? enc_up :
                        ctrl_i.cmode == CNT_UP ||
                        (ctrl_i.cmode == CNT_CENTER && !down_o);
    logic [W-1:0] next_cnt;                // Counter after tick
    logic         next_down;               // Direction after tick
    logic         next_upd;                // Limit reached
    always_comb begin
        next_cnt  = cnt_o;
        next_down = !go_up;
        next_upd  = 1'b0;
        if (srst) begin
            next_cnt = '0;                                      // [R10]
            next_upd = 1'b1;
        end else if (tick && ctrl_i.cmode == CNT_CENTER && !encoder) begin
            if (go_up && at_top) begin
                next_cnt  = at_bot ? cnt_o : cnt_o - W'(1);     // [R5]
                next_down = 1'b1;
                next_upd  = 1'b1;
            end else if (!go_up && at_bot) begin
                next_cnt  = cnt_o + W'(1);
                next_down = 1'b0;
                next_upd  = 1'b1;
            end else begin
                next_cnt = go_up ? cnt_o + W'(1) : cnt_o - W'(1);
            end
        end else if (tick && go_up) begin
            next_cnt = at_top ? '0 : cnt_o + W'(1);             // [R1] [R2]
            next_upd = at_top;                                  // [R15]
        end else if (tick) begin
            next_cnt = at_bot ? reload_i : cnt_o - W'(1);       // [R1] [R2]
            next_upd = at_bot;                                  // [R15]
        end
    end
    // ----------------------------------------
    // Counter and event registers
    // ----------------------------------------
    // Counter, direction, update strobe and sticky flag
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_o         <= '0;
            down_o        <= 1'b0;
            upd           <= 1'b0;
            update_flag_o <= 1'b0;
        end else begin
            cnt_o  <= next_cnt;
            down_o <= tick ? next_down : down_o;
            upd    <= next_upd;
            update_flag_o <= upd || (update_flag_o && !update_clr_i); // [R15]
        end
    end
    // ----------------------------------------
    // Channels
    // ----------------------------------------
    logic [3:0] ref_l;                     // Channel references
    logic [3:0] match;                     // Compare match pulses
    genvar gi;
    generate
        for (gi = 0; gi < `MCT_NUM_CH; gi++) begin : g_ch
            // Channel 0 captures on hall change when enabled
            wire logic cev = (gi == 0 && ctrl_i.hall_en) ?
                             hall_chg : pin_rise[gi];           // [R13]
            mct_channel #(.W(W)) u_ch (
                .clock_i   (clock_i),
                .nrst_i    (nrst_i),
                .cfg_i     (ch_cfg_i[gi]),
                .cmp_i     (cmp_i[gi]),
                .cnt_i     (cnt_o),
                .tick_i    (tick),
                .run_i     (run),
                .cap_evt_i (cev),
                .clr_i     (cap_clr_i[gi]),
                .ref_o     (ref_l[gi]),
                .cap_o     (cap_o[gi]),
                .flag_o    (cap_flag_o[gi]),
                .match_o   (match[gi])
            );                                                  // [R4]
        end
        // Three phases over six lines
        for (gi = 0; gi < `MCT_NUM_PAIRS; gi++) begin : g_pair
            mct_dead_time #(.DW(DW)) u_dt (
                .clock_i (clock_i),
                .nrst_i  (nrst_i),
                .ref_i   (ref_l[gi]),
                .dt_i    (dead_i),
                .off_i   (frozen),
                .p_o     (pwm_p_o[gi]),
                .n_o     (pwm_n_o[gi])
            );                                                  // [R6] [R7]
        end
    endgenerate
    // ----------------------------------------
    // Event outputs
    // ----------------------------------------
    // ADC source: update codes, else one channel match
    wire logic adc_ev = (adc_src_i >= `MCT_ADC_UPD) ? upd :
                        match[adc_src_i[1:0]];
    // Channel 3, DMA, ADC and link pulses
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ch3_o      <= 1'b0;
            dma_req_o  <= 1'b0;
            adc_trig_o <= 1'b0;
            trig_o     <= 1'b0;
        end else begin
            ch3_o      <= ref_l[3] && !frozen;                  // [R9]
            dma_req_o  <= upd && ctrl_i.dma_en;                 // [R11]
            adc_trig_o <= adc_ev;                               // [R14]
            trig_o     <= upd;                                  // [R10]
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    // Every update strobe sets the flag
    update_flag_set_a: assert property ( // [R15]
        upd |=> update_flag_o)
        else $error("update flag not raised");

    // Up count steps by one below the limit
    up_count_a: assert property ( // [R1]
        tick && !encoder && ctrl_i.cmode == CNT_UP && !at_top
        |=> cnt_o == $past(cnt_o) + W'(1))
        else $error("up count step wrong");

    // Down count reloads at zero
    down_reload_a: assert property ( // [R2]
        tick && !encoder && ctrl_i.cmode == CNT_DOWN && at_bot
        |=> cnt_o == $past(reload_i) ##1 update_flag_o)
        else $error("down count did not reload");

    // Divide by three leaves two idle cycles
    prescale_gap_a: assert property ( // [R3]
        tick && !encoder && prescale_i == PW'(2)
        ##1 ($stable(prescale_i) && $stable(ctrl_i)) [*2]
        |-> !tick && !$past(tick))
        else $error("prescaler ticked early");

    // Center count turns down at the limit
    center_turn_a: assert property ( // [R5]
        tick && !encoder && ctrl_i.cmode == CNT_CENTER && go_up &&
        at_top && !at_bot |=> down_o && cnt_o == $past(cnt_o) - W'(1))
        else $error("center count did not turn");

    // Counter holds while halted
    debug_freeze_a: assert property ( // [R9]
        frozen && !srst |=> $stable(cnt_o))
        else $error("counter moved while frozen");

    // Channel 3 held off while halted
    ch3_frozen_a: assert property ( // [R9]
        frozen |=> !ch3_o)
        else $error("channel 3 active while frozen");

    // DMA request lasts one cycle
    dma_request_a: assert property ( // [R11]
        upd && ctrl_i.dma_en |=> dma_req_o ##1 !dma_req_o)
        else $error("dma request not one pulse");

    // Encoder counts up when A leads
    encoder_step_a: assert property ( // [R12]
        tick && encoder && enc_up && !at_top
        |=> cnt_o == $past(cnt_o) + W'(1))
        else $error("encoder did not count up");

    // Update codes fire the ADC start
    adc_trigger_a: assert property ( // [R14]
        upd && adc_src_i >= `MCT_ADC_UPD |=> adc_trig_o)
        else $error("adc trigger missing");

    // Trigger edge clears the counter
    trig_reset_a: assert property ( // [R10]
        srst |=> cnt_o == '0 ##1 trig_o)
        else $error("trigger reset failed");
endmodule : motor_control_pwm_timer

// file: testbench/mct_partner.sv
// Encoder, hall sensor and power switch model for the timer
`timescale 1ns/1ps
module mct_partner (
    input  wire logic       clock_i,   // Timer clock
    input  wire logic       step_i,    // Move encoder one edge
    input  wire logic       dir_i,     // High: move backwards
    input  wire logic       hall_i,    // Toggle the hall line
    input  wire logic [2:0] p_i,       // Upper switch gates
    input  wire logic [2:0] n_i,       // Lower switch gates
    output logic [3:0]      pin_o,     // Sensor lines to timer
    output int              bad_o,     // Shoot-through cycles
    output int              gap_o      // Shortest pair-2 gap
);
    logic [1:0] ph  = 2'h0;            // Quadrature phase
    logic       hl  = 1'b0;            // Hall line level
    int         off = 0;               // Pair 2 both-off run
    initial bad_o = 0;
    initial gap_o = 1000;
    // Sensors move after an edge; switches sampled on it
    always @(posedge clock_i) begin
        if (step_i) ph <= dir_i ? ph - 2'h1 : ph + 2'h1;
        if (hall_i) hl <= ~hl;
        if ((p_i & n_i) != 3'h0) bad_o <= bad_o + 1;
        if (p_i[2] | n_i[2]) begin
            if (off > 0 && off < gap_o) gap_o <= off;
            off <= 0;
        end else off <= off + 1;
    end
    // A leads B going forwards: 00, 10, 11, 01
    assign pin_o = {1'b0, hl, ph[1], ph[1] ^ ph[0]};
endmodule : mct_partner

// file: testbench/motor_control_pwm_timer_test.sv
// Self-checking bench for the motor-control PWM timer
`timescale 1ns/1ps
`define CHK(w, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_errors++; $display("[ERR] %s exp %0h got %0h", w, e, g); end end
module motor_control_pwm_timer_test import mct_pkg::*;;
    logic          clock_i = 1'b0;  // Timer clock
    logic          nrst_i  = 1'b0;  // Reset, low
    ctrl_t         ctrl    = '0;    // Control bits
    logic [15:0]   rld     = 16'h2; // Reload limit
    logic [15:0]   psc     = 16'h0; // Prescale minus one
    ch_cfg_t [3:0] cfg     = '0;    // Channel setup
    logic [15:0]   cmp [4] = '{default: 16'h0};
    logic [7:0]    dead    = 8'h2;  // Dead time
    logic [2:0]    asrc    = 3'h0;  // ADC source
    logic          halt    = 1'b0;  // Debug halt
    logic          trig    = 1'b0;  // Trigger in
    logic          uclr    = 1'b0;  // Update clear
    logic [3:0]    cclr    = 4'h0;  // Capture clear
    logic          step    = 1'b0;  // Encoder step
    logic          dir     = 1'b0;  // Encoder direction
    logic          hall    = 1'b0;  // Hall toggle
    logic [3:0]    pins;            // Sensor lines
    logic [15:0]   cnt, base;       // Counter, reference
    logic [15:0]   cap [4];         // Captures
    logic [3:0]    cflag;           // Capture flags
    logic [2:0]    pp, pn;          // Pair outputs
    logic          down, uflag, dma, adc, trg, ch3;
    int bad, gap, k, ca, cd, cw, cycles = 0;
    int n_errors = 0, check_count = 0;
    int cp [3], cn [3];             // High-cycle tallies
    motor_control_pwm_timer motor_control_pwm_timer_inst (
        .clock_i, .nrst_i, .ctrl_i(ctrl), .reload_i(rld),
        .prescale_i(psc), .ch_cfg_i(cfg), .cmp_i(cmp), .dead_i(dead),
        .adc_src_i(asrc), .debug_halt_i(halt), .trig_i(trig),
        .pin_i(pins), .update_clr_i(uclr), .cap_clr_i(cclr),
        .cnt_o(cnt), .down_o(down), .update_flag_o(uflag),
        .cap_flag_o(cflag), .cap_o(cap), .pwm_p_o(pp), .pwm_n_o(pn),
        .ch3_o(ch3), .dma_req_o(dma), .adc_trig_o(adc), .trig_o(trg));
    mct_partner mct_partner_inst (.clock_i, .step_i(step), .dir_i(dir),
        .hall_i(hall), .p_i(pp), .n_i(pn), .pin_o(pins), .bad_o(bad),
        .gap_o(gap));
    always #2 clock_i = ~clock_i;
    // Hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask : tick
    // Tally output levels over n settled cycles
    task automatic watch(input int n);
        cp = '{0, 0, 0}; cn = '{0, 0, 0}; ca = 0; cd = 0; cw = 0;
        repeat (n) begin
            @(posedge clock_i); #1;
            for (int i = 0; i < 3; i++) begin
                cp[i] += pp[i]; cn[i] += pn[i];
            end
            ca += adc; cd += dma; cw += down;
        end
    endtask : watch
    // Cycles until the counter moves
    task automatic moved(output int c);
        logic [15:0] was;
        #1 was = cnt; c = 0;
        do begin @(posedge clock_i); #1; c++; end
        while (cnt === was && c < 200);
    endtask : moved
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    initial begin
        tick(4); #1 `CHK("rst cnt", 16'h0, cnt)
        tick(1); nrst_i <= 1'b1;
        tick(1); ctrl.enable <= 1'b1; ctrl.dma_en <= 1'b1;
        tick(1); #1 `CHK("cnt", 16'h1, cnt)
        tick(1); #1 `CHK("cnt", 16'h2, cnt)
        tick(1); #1 `CHK("wrap", 16'h0, cnt)
        tick(1); #1 `CHK("uflag", 1'b1, uflag)
        `CHK("trig", 1'b1, trg)
        `CHK("dma", 1'b1, dma)
        tick(1); asrc <= 3'h4;
        watch(15); `CHK("adc", 5, ca)
        `CHK("dma n", 5, cd)
        $display("walk and events done");
        tick(1); psc <= 16'h2; rld <= 16'd100;
        moved(k); moved(k); `CHK("psc", 3, k)
        $display("prescaler done");
        tick(1); psc <= 16'h0; rld <= 16'h3; ctrl.cmode <= CNT_DOWN;
        for (int i = 0; i < 120 && cnt !== 16'h0; i++) moved(k);
        moved(k); `CHK("reload", 16'h3, cnt)
        `CHK("down", 1'b1, down)
        $display("down count done");
        tick(1); ctrl.cmode <= CNT_UP; rld <= 16'd9;
        cfg <= {4{CH_PWM, 1'b0}}; cmp <= '{16'd0, 16'd10, 16'd5, 16'd5};
        tick(30); watch(20);
        `CHK("duty 0", 0, cp[0])
        `CHK("duty 0 n", 20, cn[0])
        `CHK("duty full", 20, cp[1])
        `CHK("duty mid", 1'b1, cp[2] > 0 && cp[2] < 10)
        `CHK("dead", 1'b1, gap >= 3)
        tick(1); ctrl.cmode <= CNT_CENTER;
        tick(30); watch(36);
        `CHK("center", 1'b1, cw > 0 && cw < 36)
        `CHK("center pwm", 1'b1, cp[2] > 0 && cn[2] > 0)
        $display("pwm done");
        tick(1); ctrl.freeze_en <= 1'b1; halt <= 1'b1;
        tick(2); #1 base = cnt;
        watch(8); `CHK("frozen", base, cnt)
        `CHK("off", 0, cp[0] + cp[1] + cp[2] + cn[0] + cn[1] + cn[2])
        `CHK("ch3 off", 1'b0, ch3)
        `CHK("overlap", 0, bad)
        tick(1); uclr <= 1'b1;
        tick(1); uclr <= 1'b0;
        tick(1); #1 `CHK("uclr", 1'b0, uflag)
        $display("freeze done");
        tick(1); halt <= 1'b0; ctrl.smode <= SLV_ENCODER; rld <= 16'd100;
        ctrl.cmode <= CNT_UP;
        for (int d = 0; d < 2; d++) begin
            tick(10); #1 base = cnt;
            repeat (4) begin
                tick(1); step <= 1'b1;
                tick(1); step <= 1'b0;
                tick(6);
            end
            tick(8); #1 `CHK("enc", d ? base - 16'h4 : base + 16'h4, cnt)
            tick(1); dir <= 1'b1;
        end
        $display("encoder done");
        tick(1); ctrl.smode <= SLV_FREE; ctrl.hall_en <= 1'b1;
        cfg[0] <= '{CH_CAPTURE, 1'b0}; cclr <= 4'hf;
        tick(1); cclr <= 4'h0;
        tick(8); #1 `CHK("no cap", 1'b0, cflag[0])
        tick(1); hall <= 1'b1;
        tick(1); hall <= 1'b0;
        tick(10); #1 `CHK("hall cap", 1'b1, cflag[0])
        `CHK("hall val", cnt - 16'h6, cap[0])
        $display("hall done");
        tick(1); ctrl.smode <= SLV_RESET;
        tick(20); trig <= 1'b1;
        tick(2); #1 `CHK("sync rst", 1'b1, cnt < 16'h2)
        $display("trigger done");
        final_report();
    end
endmodule : motor_control_pwm_timer_test
